// file: sim/test_vid_monitor_channel_select.sv
/*
 Testbench: host end and monitor joined by the link, driven over Wishbone.
 Assumes the package decode weights; expected values are worked by hand.
*/
`timescale 1ns/10ps
`default_nettype none
module test_vid_monitor_channel_select;
   import vmc_pkg::*;
   logic clk;
   logic nrst;
   logic [7:0] adr;
   logic [31:0] dat_w;
   logic [31:0] wb_q;
   logic [3:0] sel;
   logic we_w, cyc, stb, wb_ack;
   logic [7:0] core_supply;
   logic alert_n, single_mode, channel_valid, battery_continuous;
   logic code_monitor_enable, core_lsb_fine;
   logic [15:0] divider_bypass;
   logic [4:0] single_channel;
   logic [31:0] q;
   int n_mismatch, samples_checked, cycles;
   vmc_link_if u_vmc_link_if (.clk(clk), .nrst(nrst));
   vmc_monitor u_vmc_monitor (.lnk(u_vmc_link_if.dev_mp), .core_supply(core_supply),
      .alert_n(alert_n), .divider_bypass(divider_bypass), .single_mode(single_mode),
      .single_channel(single_channel), .channel_valid(channel_valid),
      .battery_continuous(battery_continuous), .code_monitor_enable(code_monitor_enable),
      .core_lsb_fine(core_lsb_fine));
   vmc_host u_vmc_host (.lnk(u_vmc_link_if.host_mp), .wb_adr_i(adr), .wb_dat_i(dat_w),
      .wb_sel_i(sel), .wb_we_i(we_w), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(wb_q),
      .wb_ack_o(wb_ack));
   vmc_link_chk u_vmc_link_chk (.clk(clk), .nrst(nrst), .code_line(u_vmc_link_if.code_line),
      .req(u_vmc_link_if.req), .we(u_vmc_link_if.we), .addr(u_vmc_link_if.addr),
      .wdata(u_vmc_link_if.wdata), .ack(u_vmc_link_if.ack), .rdata(u_vmc_link_if.rdata));
   // ------
   // Bus and compare tasks
   // ------
   task test_done;
      $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chkv(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask
   // Classic single cycle; held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      dat_w <= d;
      we_w <= w;
      sel <= 4'hf;
      cyc <= 1'b1;
      stb <= 1'b1;
      do @(posedge clk); while (wb_ack !== 1'b1);
      r = wb_q;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // One link transfer; returns the host status once no longer busy
   task dev(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] s);
      wb(1'b1, H_CMD, {15'h0, w, d, a}, s);
      do wb(1'b0, H_STAT, 32'h0, s); while (s[0] === 1'b1);
   endtask
   // Out-of-window value, then back inside: sticky status, clear on read
   task t_edge(input logic [7:0] meas, input logic f, input logic [7:0] inw);
      core_supply <= meas;
      repeat (8) @(posedge clk);
      chk1(alert_n, !f);
      dev(1'b0, A_DSTAT, 8'h0, q);
      chkv(16'(q[9:2]), {9'h0, f, 6'h0});
      core_supply <= inw;
      repeat (8) @(posedge clk);
      chk1(alert_n, !f);
      dev(1'b0, A_DSTAT, 8'h0, q);
      chkv(16'(q[9:2]), {9'h0, f, 6'h0});
      dev(1'b0, A_DSTAT, 8'h0, q);
      chkv(16'(q[9:2]), 16'h0);
      chk1(alert_n, 1'b1);
   endtask
   // ------
   // Scenarios
   // ------
   task t_reset;
      logic [7:0] regs [10];
      regs = '{A_CFG0, A_PINCFG1, A_CONV, A_BYP1, A_BYP2, A_WINDOW, A_CODE, A_DSTAT,
         A_DMASK, 8'h55};
      dev(1'b1, 8'h55, 8'hff, q);
      for (int i = 0; i < 10; i++)
      begin
         dev(1'b0, regs[i], 8'h0, q);
         chkv(16'(q[9:2]), 16'h0);
      end
      chk1(alert_n, 1'b1);
   endtask
   task t_convert;
      dev(1'b1, A_BYP1, 8'ha5, q);
      dev(1'b1, A_BYP2, 8'h3c, q);
      chkv(divider_bypass, 16'h3ca5);
      for (int ch = 0; ch < 18; ch++)
      begin
         dev(1'b1, A_CONV, {ch[4:0], 3'b100}, q);
         chk1(single_mode, 1'b1);
         chkv({11'h0, single_channel}, 16'(ch));
         chk1(channel_valid, ch != 15);
         chk1(battery_continuous, ch == 0);
      end
      dev(1'b1, A_PINCFG1, 8'h80, q);
      chk1(q[1], 1'b1);
      chk1(code_monitor_enable, 1'b0);
      dev(1'b1, A_CONV, 8'h00, q);
      chk1(single_mode, 1'b0);
   endtask
   task t_monitor;
      dev(1'b1, A_WINDOW, 8'h40, q);
      dev(1'b0, A_WINDOW, 8'h0, q);
      chkv(16'(q[9:2]), 16'h41);
      dev(1'b1, A_WINDOW, 8'h44, q);
      wb(1'b1, H_DRIVE, 32'h7f, q);
      core_supply <= 8'd76;
      dev(1'b1, A_PINCFG1, 8'h80, q);
      chk1(code_monitor_enable, 1'b1);
      chk1(core_lsb_fine, 1'b1);
      repeat (6600) @(posedge clk);
      chk1(alert_n, 1'b1);
      repeat (11000) @(posedge clk);
      dev(1'b0, A_CODE, 8'h0, q);
      chkv(16'(q[9:2]), 16'h3f);
      // Table A code 3f decodes below the floor and clamps to 670
      t_edge(8'd76, 1'b1, 8'd67);
      t_edge(8'd75, 1'b0, 8'd67);
      t_edge(8'd63, 1'b1, 8'd67);
      t_edge(8'd64, 1'b0, 8'd67);
      dev(1'b1, A_DMASK, 8'h40, q);
      core_supply <= 8'd76;
      repeat (8) @(posedge clk);
      chk1(alert_n, 1'b1);
      dev(1'b0, A_DSTAT, 8'h0, q);
      chkv(16'(q[9:2]), 16'h40);
      core_supply <= 8'd67;
      dev(1'b0, A_DSTAT, 8'h0, q);
      dev(1'b1, A_DMASK, 8'h00, q);
      // Table B: code 41 weighs 320+5, expect 955
      core_supply <= 8'd97;
      dev(1'b1, A_CFG0, 8'h40, q);
      wb(1'b1, H_DRIVE, 32'h41, q);
      repeat (17600) @(posedge clk);
      dev(1'b0, A_CODE, 8'h0, q);
      chkv(16'(q[9:2]), 16'h41);
      // The table switch may leave a stale flag; clear it while in window
      dev(1'b0, A_DSTAT, 8'h0, q);
      chk1(alert_n, 1'b1);
      t_edge(8'd104, 1'b1, 8'd97);
      t_edge(8'd103, 1'b0, 8'd97);
      t_edge(8'd91, 1'b1, 8'd97);
      t_edge(8'd92, 1'b0, 8'd97);
   endtask
   // Clock, hang guard and main sequence
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 80000)
      begin
         n_mismatch++;
         test_done();
      end
   end
   initial
   begin
      nrst = 1'b0;
      {adr, dat_w, sel, we_w, cyc, stb} = '0;
      core_supply = 8'd0;
      sel = 4'hf;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_convert();
      t_monitor();
      test_done();
   end
endmodule
`default_nettype wire

// file: sim/vmc_link_chk.sv
/*
 Checker for the link between the code monitor and its host end.
 Assumes one clock and an active-low asynchronous reset for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module vmc_link_chk
   import vmc_pkg::*;
(
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic [6:0] code_line, // Code lines
   input wire logic req, // Request
   input wire logic we, // Write
   input wire logic [7:0] addr, // Offset
   input wire logic [7:0] wdata, // Write data
   input wire logic ack, // Answer
   input wire logic [7:0] rdata // Read data
);
   logic take;
   logic tb_r;
   logic sm_r;
   logic en_r;
   assign take = req && !ack;
   // Shadows of written mode bits; the wire alone cannot tell them
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         tb_r <= 1'b0;
         sm_r <= 1'b0;
         en_r <= 1'b0;
      end
      else if (take && we)
      begin
         if (addr == A_CFG0)
            tb_r <= wdata[B_TABLE_B];
         if (addr == A_CONV)
            sm_r <= wdata[B_SINGLE];
         if (addr == A_PINCFG1)
            en_r <= wdata[B_MON_EN];
      end
   end
   // ------
   // Properties
   // ------
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_ack_next; take |=> ack; endproperty
   a_ack_next: assert property (p_ack_next) else $error("no ack after take");
   property p_ack_pulse; ack |=> !ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_req_hold; take |=> req && $stable({we, addr, wdata}); endproperty
   a_req_hold: assert property (p_req_hold) else $error("request moved");
   property p_req_drop; ack |=> !req; endproperty
   a_req_drop: assert property (p_req_drop) else $error("req held after ack");
   property p_rdata_keep; ack && we |-> $stable(rdata); endproperty
   a_rdata_keep: assert property (p_rdata_keep) else $error("rdata moved on write");
   property p_code_top; ack && !we && addr == A_CODE |-> !rdata[7]; endproperty
   a_code_top: assert property (p_code_top) else $error("code bit 7 set");
   property p_line6; !tb_r && !$past(tb_r, 2) |-> !code_line[6]; endproperty
   a_line6: assert property (p_line6) else $error("line 6 high");
   property p_window_low; take && we && addr == A_WINDOW |-> wdata[3:0] != 4'h0; endproperty
   a_window_low: assert property (p_window_low) else $error("low limit zero");
   property p_pin_locked; take && we && addr == A_PINCFG1 |-> !sm_r; endproperty
   a_pin_locked: assert property (p_pin_locked) else $error("pin setup in single");
   property p_code_off;
      ack && !we && addr == A_CODE && !en_r && !$past(en_r, 4) |-> rdata == 8'h00;
   endproperty
   a_code_off: assert property (p_code_off) else $error("code read while off");
endmodule
`default_nettype wire

// file: verilog/vmc_code_decode.sv
/*
 Turns a sampled code into the expected supply voltage, in 1.25 mV units,
 under either regulator table, clamped to the decodable span.
 Assumes a code that is stable for the caller; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module vmc_code_decode
   import vmc_pkg::*;
(
   input wire logic [6:0] code, // Sampled code
   input wire logic table_b,    // Second table selected
   output logic [11:0] volts    // Expected voltage
);
   logic [11:0] sum;
   logic [11:0] raw;

   // ------------------------------------------------------------
   // Weighted lookup; each set line except line 6 under the first table steps the voltage down from the base
   // ------------------------------------------------------------
   always_comb
   begin
      sum = 12'h000;
      for (int i = 0; i < 7; i++)
         if (code[i])
            sum = sum + {2'b00, (table_b ? W_B[i] : W_A[i])};
      raw = (table_b ? BASE_B : BASE_A) - sum;
      // Clamp so a stray code cannot leave the decodable span
      if (raw < V_MIN)
         volts = V_MIN;
      else if (raw > V_MAX)
         volts = V_MAX;
      else
         volts = raw;
   end
endmodule
`default_nettype wire

// file: verilog/vmc_host.sv
/*
 Host end: drives the processor code lines and runs register transfers on
 the link on behalf of software, which reaches it over classic Wishbone.
 Assumes one transfer at a time; software polls the busy bit.
*/
`timescale 1ns/10ps
`default_nettype none
module vmc_host
   import vmc_pkg::*;
(
   vmc_link_if.host_mp lnk,        // Link to the monitor
   input wire logic [7:0] wb_adr_i, // Byte address
   input wire logic [31:0] wb_dat_i, // Write data
   input wire logic [3:0] wb_sel_i, // Byte lanes
   input wire logic wb_we_i,       // Write
   input wire logic wb_cyc_i,      // Cycle
   input wire logic wb_stb_i,      // Strobe
   output logic [31:0] wb_dat_o,   // Read data
   output logic wb_ack_o           // Answer
);
   typedef enum logic [1:0] {S_IDLE = 2'b01, S_WAIT = 2'b10} vmc_hstate_t;
   vmc_hstate_t state_r;
   logic wb_ack_r;
   logic [31:0] wb_dat_r;
   logic [16:0] cmd_r;
   logic [6:0] drive_r;
   logic [7:0] last_r;
   logic refused_r;
   logic single_sh_r;
   logic table_b_sh_r;
   logic req_r;
   logic we_r;
   logic [7:0] addr_r;
   logic [7:0] wdata_r;
   logic [6:0] line_r;
   logic acc;
   logic go;
   logic [31:0] cmd_nxt;
   logic [7:0] wd_fix;
   logic blocked;

   assign acc = wb_cyc_i & wb_stb_i & ~wb_ack_r;
   assign go = acc & wb_we_i & (wb_adr_i == H_CMD) & (state_r == S_IDLE);

   // ------------------------------------------------------------
   // Wishbone slave
   // ------------------------------------------------------------
   // Byte-lane merge of the command word
   always_comb
   begin
      cmd_nxt = {15'h0000, cmd_r};
      for (int b = 0; b < 4; b++)
         if (wb_sel_i[b])
            cmd_nxt[b*8 +: 8] = wb_dat_i[b*8 +: 8];
   end

   // Answer in the cycle after the request; unmapped reads give zero
   always_ff @(posedge lnk.clk or negedge lnk.nrst)
   begin
      if (!lnk.nrst)
      begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= 32'h0000_0000;
         cmd_r <= 17'h0_0000;
         drive_r <= 7'h00;
      end
      else
      begin
         wb_ack_r <= acc;
         if (acc & ~wb_we_i)
            case (wb_adr_i)
               H_CMD: wb_dat_r <= {15'h0000, cmd_r};
               H_STAT: wb_dat_r <= {22'h00_0000, last_r, refused_r,
                  state_r == S_WAIT};
               H_DRIVE: wb_dat_r <= {25'h000_0000, drive_r};
               default: wb_dat_r <= 32'h0000_0000;
            endcase
         if (go)
            cmd_r <= cmd_nxt[16:0];
         if (acc & wb_we_i & (wb_adr_i == H_DRIVE) & wb_sel_i[0])
            drive_r <= wb_dat_i[6:0];
      end
   end

   // ------------------------------------------------------------
   // Link transfers
   // ------------------------------------------------------------
   // Pin setup is frozen while the converter sits on one channel
   assign blocked = cmd_nxt[H_WE_BIT] & (cmd_nxt[7:0] == A_PINCFG1) & single_sh_r;
   // A zero low limit would flag any reading at or below the expected value, so it is raised to the minimum
   assign wd_fix = (cmd_nxt[7:0] == A_WINDOW) & (cmd_nxt[11:8] == 4'h0)
      ? {cmd_nxt[15:12], LOW_MIN} : cmd_nxt[15:8];

   always_ff @(posedge lnk.clk or negedge lnk.nrst)
   begin
      if (!lnk.nrst)
      begin
         state_r <= S_IDLE;
         req_r <= 1'b0;
         we_r <= 1'b0;
         addr_r <= 8'h00;
         wdata_r <= 8'h00;
         last_r <= 8'h00;
         refused_r <= 1'b0;
         single_sh_r <= 1'b0;
         table_b_sh_r <= 1'b0;
      end
      else
         case (state_r)
            S_IDLE:
               if (go)
               begin
                  refused_r <= blocked;
                  if (!blocked)
                  begin
                     req_r <= 1'b1;
                     we_r <= cmd_nxt[H_WE_BIT];
                     addr_r <= cmd_nxt[7:0];
                     wdata_r <= wd_fix;
                     state_r <= S_WAIT;
                  end
               end
            S_WAIT:
               if (lnk.ack)
               begin
                  req_r <= 1'b0;
                  state_r <= S_IDLE;
                  if (!we_r)
                     last_r <= lnk.rdata;
                  if (we_r & (addr_r == A_CONV))
                     single_sh_r <= wdata_r[B_SINGLE];
                  if (we_r & (addr_r == A_CFG0))
                     table_b_sh_r <= wdata_r[B_TABLE_B];
               end
            default: state_r <= S_IDLE;
         endcase
   end

   // Line 6 held low while the first table is in use
   always_ff @(posedge lnk.clk or negedge lnk.nrst)
   begin
      if (!lnk.nrst)
         line_r <= 7'h00;
      else
         line_r <= {drive_r[6] & table_b_sh_r, drive_r[5:0]};
   end

   assign lnk.code_line = line_r;
   assign lnk.req = req_r;
   assign lnk.we = we_r;
   assign lnk.addr = addr_r;
   assign lnk.wdata = wdata_r;
   assign wb_dat_o = wb_dat_r;
   assign wb_ack_o = wb_ack_r;
endmodule
`default_nettype wire

// file: verilog/vmc_link_if.sv
/*
 Link between the code monitor and its host end: seven code lines from the
 processor and a simple request/acknowledge register port.
 Assumes one clock and one reset for both ends.
*/
`timescale 1ns/10ps
`default_nettype none
interface vmc_link_if (
   input wire logic clk, // System clock
   input wire logic nrst // Async reset, active low
);
   logic [6:0] code_line; // Code lines 0..6
   logic req;             // Register request, held until ack
   logic we;              // Request is a write
   logic [7:0] addr;      // Register offset
   logic [7:0] wdata;     // Write data
   logic ack;             // One-cycle answer
   logic [7:0] rdata;     // Read data, valid with ack
   modport dev_mp (input clk, nrst, code_line, req, we, addr, wdata,
      output ack, rdata);
   modport host_mp (input clk, nrst, ack, rdata,
      output code_line, req, we, addr, wdata);
endinterface
`default_nettype wire

// file: verilog/vmc_monitor.sv
/*
 Device end of the code monitor: configuration registers, single-channel
 conversion control, divider bypass, code sampling, window compare against
 core supply channel 1, sticky mismatch status and the alert output.
 Assumes the measured supply value comes from the converter already
 settled, and that the link's register port holds req until ack.
*/
// Local design decision: the Wishbone register port.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Bypass bits remove that channel's divider
// - Conversion bit 2 selects single-channel mode
// - Bits 7:3 pick the single channel
// - Single channel converts repeatedly, battery included
// - Host leaves pin setup alone in single mode
// - Captured code stored, readable by host
// - Pin config bit 7 enables all code lines
// - Code bits 0..6 mirror lines; bit 7 zero
// - Config bit 6 selects second table
// - Second table weights 400 down to 6.25
// - First table uses six lines, line 6 zero
// - Lines sampled every 11 us into register
// - Compare only after 55 us stable code
// - Monitoring sets supply step to 12.5 mV
// - Decoded voltage spans 0.8375 to 1.6 V
// - Window register: high and low offset nibbles
// - High is greater-than, low is less-or-equal
// - Mismatch sets status bit 6, may alert
// - Status read clears only if now matching
// - Status stays set until read and cleared
// - Mask blocks alert, status still sets
module vmc_monitor
   import vmc_pkg::*;
(
   vmc_link_if.dev_mp lnk,              // Code lines and register port
   input wire logic [7:0] core_supply,  // Measured core supply channel 1
   output logic alert_n,                // Alert, active low
   output logic [15:0] divider_bypass,  // Per-channel divider removed
   output logic single_mode,            // Converter in single-channel mode
   output logic [4:0] single_channel,   // Channel converted in single mode
   output logic channel_valid,          // Selected channel code exists
   output logic battery_continuous,     // Battery input converted nonstop
   output logic code_monitor_enable,    // Code pins claimed as inputs
   output logic core_lsb_fine           // Supply step is 12.5 mV
);
   logic clk;
   logic nrst;
   logic [7:0] cfg0_r;
   logic [7:0] pincfg1_r;
   logic [7:0] conv_r;
   logic [7:0] byp1_r;
   logic [7:0] byp2_r;
   logic [7:0] dmask_r;
   logic [7:0] window_r;
   logic [6:0] code_r;
   logic mismatch_r;
   logic ack_r;
   logic [7:0] rdata_r;
   logic [11:0] tick_r;
   logic [2:0] stable_r;
   logic armed_r;
   logic fault_r;
   logic alert_n_r;
   logic [15:0] bypass_r;
   logic single_r;
   logic [4:0] chan_r;
   logic chan_ok_r;
   logic batt_r;
   logic mon_r;
   logic take;
   logic wr;
   logic rd_status;
   logic tick;
   logic table_b;
   logic [6:0] sample;
   logic [11:0] expect_v;
   logic [12:0] meas_v;
   logic [12:0] high_v;
   logic [12:0] low_v;
   logic fault_now;

   assign clk = lnk.clk;
   assign nrst = lnk.nrst;

   // ------------------------------------------------------------
   // Register port
   // ------------------------------------------------------------
   // A request is taken once; ack drops the cycle after it was given
   assign take = lnk.req & ~ack_r;
   assign wr = take & lnk.we;
   assign rd_status = take & ~lnk.we & (lnk.addr == A_DSTAT);
   assign table_b = cfg0_r[B_TABLE_B];

   // Acknowledge and read data
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ack_r <= 1'b0;
         rdata_r <= REG_RST;
      end
      else
      begin
         ack_r <= take;
         if (take & ~lnk.we)
            case (lnk.addr)
               A_CFG0: rdata_r <= cfg0_r;
               A_PINCFG1: rdata_r <= pincfg1_r;
               A_CONV: rdata_r <= conv_r;
               A_BYP1: rdata_r <= byp1_r;
               A_BYP2: rdata_r <= byp2_r;
               A_DMASK: rdata_r <= dmask_r;
               A_WINDOW: rdata_r <= window_r;
               A_CODE: rdata_r <= {1'b0, code_r};
               A_DSTAT: rdata_r <= {1'b0, mismatch_r, 6'b00_0000};
               default: rdata_r <= REG_RST;
            endcase
      end
   end

   // Writable configuration; unknown offsets are ignored
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cfg0_r <= REG_RST;
         pincfg1_r <= REG_RST;
         conv_r <= REG_RST;
         byp1_r <= REG_RST;
         byp2_r <= REG_RST;
         dmask_r <= REG_RST;
         window_r <= REG_RST;
      end
      else if (wr)
         case (lnk.addr)
            A_CFG0: cfg0_r <= lnk.wdata;
            A_PINCFG1: pincfg1_r <= lnk.wdata;
            A_CONV: conv_r <= lnk.wdata;
            A_BYP1: byp1_r <= lnk.wdata;
            A_BYP2: byp2_r <= lnk.wdata;
            A_DMASK: dmask_r <= lnk.wdata;
            A_WINDOW: window_r <= lnk.wdata;
            default: ;
         endcase
   end

   // ------------------------------------------------------------
   // Converter and front-end control
   // ------------------------------------------------------------
   // Registered copies so every output leaves a flip-flop
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         bypass_r <= 16'h0000;
         single_r <= 1'b0;
         chan_r <= 5'h00;
         chan_ok_r <= 1'b0;
         batt_r <= 1'b0;
         mon_r <= 1'b0;
      end
      else
      begin
         bypass_r <= {byp2_r, byp1_r};
         single_r <= conv_r[B_SINGLE];
         chan_r <= conv_r[7:3];
         chan_ok_r <= (conv_r[7:3] <= CHAN_LAST) & (conv_r[7:3] != CHAN_GAP);
         // Repeated conversion of the battery input drains the cell
         batt_r <= conv_r[B_SINGLE] & (conv_r[7:3] == CHAN_BATT);
         mon_r <= pincfg1_r[B_MON_EN];
      end
   end

   // ------------------------------------------------------------
   // Code sampling
   // ------------------------------------------------------------
   assign tick = (tick_r == SAMPLE_LAST);
   // Line 6 is grounded under the first table and reads as zero
   assign sample = {lnk.code_line[6] & table_b, lnk.code_line[5:0]};

   // Sample period counter
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         tick_r <= 12'h000;
      else if (tick | ~mon_r)
         tick_r <= 12'h000;
      else
         tick_r <= tick_r + 12'h001;
   end

   // Stored code and stability count; arming waits for a settled code
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         code_r <= 7'h00;
         stable_r <= 3'h0;
         armed_r <= 1'b0;
      end
      else if (!mon_r)
      begin
         code_r <= 7'h00;
         stable_r <= 3'h0;
         armed_r <= 1'b0;
      end
      else if (tick)
      begin
         code_r <= sample;
         if (sample != code_r)
            stable_r <= 3'h0;
         else if (stable_r != STABLE_CNT)
            stable_r <= stable_r + 3'h1;
         armed_r <= (sample == code_r) & (stable_r >= STABLE_CNT - 3'h1);
      end
   end

   // ------------------------------------------------------------
   // Window compare
   // ------------------------------------------------------------
   vmc_code_decode u_decode (
      .code(code_r),
      .table_b(table_b),
      .volts(expect_v)
   );

   assign meas_v = vmc_scale(core_supply, K_MEAS);
   assign high_v = vmc_scale({4'h0, window_r[7:4]}, K_HIGH);
   assign low_v = vmc_scale({4'h0, window_r[3:0]}, K_LOW);
   // Low side added to the measurement so nothing underflows
   assign fault_now = (meas_v > {1'b0, expect_v} + high_v)
      | (meas_v + low_v <= {1'b0, expect_v});

   // Fault is registered to keep the compare path short
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         fault_r <= 1'b0;
      else
         fault_r <= armed_r & fault_now;
   end

   // Sticky status: a live fault wins over the clearing read
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         mismatch_r <= 1'b0;
      else if (fault_r)
         mismatch_r <= 1'b1;
      else if (rd_status)
         mismatch_r <= 1'b0;
   end

   // Alert follows the unmasked status bit
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         alert_n_r <= 1'b1;
      else
         alert_n_r <= ~(mismatch_r & ~dmask_r[B_MISMATCH]);
   end

   assign lnk.ack = ack_r;
   assign lnk.rdata = rdata_r;
   assign alert_n = alert_n_r;
   assign divider_bypass = bypass_r;
   assign single_mode = single_r;
   assign single_channel = chan_r;
   assign channel_valid = chan_ok_r;
   assign battery_continuous = batt_r;
   assign code_monitor_enable = mon_r;
   assign core_lsb_fine = mon_r;
endmodule
`default_nettype wire

// file: verilog/vmc_pkg.sv
/*
 Shared constants for the code monitor and its host end: register offsets,
 field positions, reset values, decode weights and timing counts.
 Assumes a 200 MHz clock shared by both ends.
*/
`default_nettype none
package vmc_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int SAMPLE_US = 11;
   localparam int STABLE_US = 55;
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int STABLE_SAMPLES = STABLE_US / SAMPLE_US;
   localparam logic [11:0] SAMPLE_LAST = 12'(SAMPLE_CYC - 1);
   localparam logic [2:0] STABLE_CNT = 3'(STABLE_SAMPLES);
   // ------------------------------------------------------------
   // Device register offsets and fields
   // ------------------------------------------------------------
   localparam logic [7:0] A_CFG0 = 8'h00;
   localparam logic [7:0] A_PINCFG1 = 8'h10;
   localparam logic [7:0] A_CONV = 8'h16;
   localparam logic [7:0] A_BYP1 = 8'h18;
   localparam logic [7:0] A_BYP2 = 8'h19;
   localparam logic [7:0] A_DMASK = 8'h35;
   localparam logic [7:0] A_WINDOW = 8'h78;
   localparam logic [7:0] A_CODE = 8'h97;
   localparam logic [7:0] A_DSTAT = 8'hbe;
   localparam int B_TABLE_B = 6;
   localparam int B_MON_EN = 7;
   localparam int B_SINGLE = 2;
   localparam int B_MISMATCH = 6;
   localparam logic [7:0] REG_RST = 8'h00;
   localparam logic [4:0] CHAN_LAST = 5'h11;
   localparam logic [4:0] CHAN_GAP = 5'h0f;
   localparam logic [4:0] CHAN_BATT = 5'h00;
   localparam logic [3:0] LOW_MIN = 4'h1;
   // ------------------------------------------------------------
   // Voltages in units of 1.25 mV
   // ------------------------------------------------------------
   localparam logic [11:0] V_MIN = 12'd670;
   localparam logic [11:0] V_MAX = 12'd1280;
   localparam logic [11:0] BASE_A = 12'd1280;
   localparam logic [11:0] BASE_B = 12'd1280;
   localparam logic [4:0] K_MEAS = 5'd10;
   localparam logic [4:0] K_HIGH = 5'd20;
   localparam logic [4:0] K_LOW = 5'd10;
   // Weights per line, line 0 first
   localparam logic [9:0] W_A [7] = '{10'd20, 10'd48, 10'd80, 10'd160, 10'd320,
      10'd10, 10'd0};
   localparam logic [9:0] W_B [7] = '{10'd5, 10'd10, 10'd20, 10'd40, 10'd80,
      10'd160, 10'd320};
   // ------------------------------------------------------------
   // Host end registers (Wishbone byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] H_CMD = 8'h00;
   localparam logic [7:0] H_STAT = 8'h04;
   localparam logic [7:0] H_DRIVE = 8'h08;
   localparam int H_WE_BIT = 16;

   // Scale an 8-bit value by a small factor into voltage units
   function automatic logic [12:0] vmc_scale(input logic [7:0] v, input logic [4:0] k);
      vmc_scale = 13'(v) * 13'(k);
   endfunction
endpackage
`default_nettype wire
